/* File: pkg/slps_pkg.sv */
package slps_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_ILAS_DEVICE_ID   = 12'h206;
  localparam logic [11:0] IDX_END_OF_FRAME_SEL = 12'h207;
  localparam logic [11:0] IDX_LINK_STATUS      = 12'h208;
  localparam logic [11:0] IDX_CHANNEL_PWR_OFF  = 12'h209;
  localparam logic [11:0] IDX_IRQ_STATUS       = 12'h210;
  localparam logic [11:0] IDX_IRQ_MASK         = 12'h211;

  // Reset values
  localparam logic [7:0] RST_ILAS_DEVICE_ID = 8'h00;
  localparam logic [1:0] RST_EOF_CHAR_SEL   = 2'h0;
  localparam logic [1:0] RST_CHAN_PWR_OFF   = 2'h0;
  localparam logic [3:0] RST_IRQ_MASK       = 4'h0;

  // Status register bit positions
  localparam int STAT_LINK_UP_BIT   = 6;
  localparam int STAT_SYNC_BIT      = 5;
  localparam int STAT_REALIGN_BIT   = 4;
  localparam int STAT_PHASE_SET_BIT = 3;
  localparam int STAT_PLL_LOCK_BIT  = 2;

  // Channel power-off bit positions
  localparam int PD_CHAN_A_BIT = 0;
  localparam int PD_CHAN_B_BIT = 1;

  // Interrupt status and mask bit positions
  localparam int IRQ_REALIGN_BIT   = 0;
  localparam int IRQ_PHASE_SET_BIT = 1;
  localparam int IRQ_LINK_UP_BIT   = 2;
  localparam int IRQ_PLL_LOSS_BIT  = 3;
  localparam int IRQ_W             = 4;

  // End-of-frame comma selections
  localparam logic [1:0] EOF_SEL_K28_7 = 2'h0;
  localparam logic [1:0] EOF_SEL_K28_1 = 2'h1;
  localparam logic [1:0] EOF_SEL_K28_5 = 2'h2;

  // Control character byte values (K flag is carried separately)
  localparam logic [7:0] KCHAR_28_7 = 8'hfc;
  localparam logic [7:0] KCHAR_28_1 = 8'h3c;
  localparam logic [7:0] KCHAR_28_5 = 8'hbc;

  // AHB transfer type upper bit marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;

  // Identifier step between link A and link B
  localparam logic [7:0] DID_LINK_B_STEP = 8'h01;

endpackage : slps_pkg

/* File: verilog/slps_sync2.sv */
`timescale 1ns/1ps
module slps_sync2
  import slps_pkg::*;
#(
  parameter int WIDTH = 2
)(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } slps_sync_state_type;

  slps_sync_state_type st_q;
  slps_sync_state_type st_d;

  if (WIDTH < 1)
  begin : g_chk
    $error("slps_sync2 needs WIDTH of at least one");
  end

  // First stage feeds only the second stage
  always_comb
  begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule : slps_sync2

/* File: verilog/slps_regs.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Functional notes
// - In ILAS second multiframe send identifier on link A, identifier plus one on B.
// - Identifier bit 0 is dropped on write and always reads zero.
// - Comma select 0 gives K28.7, 1 gives K28.1, 2 gives K28.5; 3 reserved.
// - End-of-frame comma inserted opportunistically, only in 8b/10b link modes.
// - Status bit 6 is high while the serial link is up.
// - Status bit 5 reads 0 while SYNC~ asserted, 1 while de-asserted.
// - Status bit 4 set by SYSREF clock realignment; write one clears.
// - Status bit 3 set by first SYSREF after encoder enable; write one clears.
// - Status bit 2 is high while the serializer PLL is locked.
// - Power-off bit 1 powers down channel B and digital channels bound to B.
// - Power-off bit 0 powers down channel A and digital channels bound to A.
// - Both channels off powers down the whole link subsystem, PLL and multiframe clock.
// - Both channels on link A with B channel disabled: link A runs, B samples undefined.
module slps_regs
  import slps_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  // AHB-Lite slave
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Pins from the receiver and serializer PLL
  input  wire logic              sync_n_pin,
  input  wire logic              pll_lock_pin,
  // Link logic on the same clock
  input  wire logic              serial_link_enable,
  input  wire logic              link_up_in,
  input  wire logic              mode_8b10b,
  input  wire logic              mode_ab_on_link_a,
  input  wire logic [1:0]        digital_channel_binding,
  input  wire logic [1:0]        digital_channel_enable,
  input  wire logic              sysref_realign,
  input  wire logic              sysref_event,
  input  wire logic              ilas_mf2_a,
  input  wire logic              ilas_mf2_b,
  input  wire logic              eof_opportunity,
  // ILAS identifier octets
  output logic      [7:0]        did_octet_a,
  output logic      [7:0]        did_octet_b,
  // End-of-frame comma
  output logic                   eof_insert,
  output logic      [7:0]        eof_kchar,
  // Power control
  output logic                   chan_a_power_off,
  output logic                   chan_b_power_off,
  output logic      [1:0]        digital_chan_pd,
  output logic                   link_subsys_pd,
  output logic                   b_samples_undef,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    logic [7:0]       ilas_device_id;
    logic [1:0]       end_of_frame_char_sel;
    logic [1:0]       pd;
    logic             link_up;
    logic             sync_ok;
    logic             realigned;
    logic             phase_set;
    logic             pll_lock;
    logic             armed;
    logic             en_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             wr_pend;
    logic [11:0]      wr_idx;
    logic [31:0]      rdata;
    logic [7:0]       did_a;
    logic [7:0]       did_b;
    logic             eof_ins;
    logic [7:0]       eof_k;
    logic [1:0]       dig_pd;
    logic             subsys_pd;
    logic             b_undef;
  } slps_state_type;

  slps_state_type st_q;
  slps_state_type st_d;
  logic [1:0]     pin_sync;
  logic           sync_n_s;
  logic           pll_lock_s;

  if (ADDR_W < 14)
  begin : g_chk
    $error("slps_regs needs ADDR_W of at least 14");
  end

  // Word index of a byte address, or all ones when outside the decoded window
  function automatic logic [11:0] idx_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] hi;
    hi = a >> 14;
    if (hi != '0)
      return 12'hfff;
    return a[13:2];
  endfunction : idx_of

  // Comma byte for a select value; reserved code falls back to the compliant comma
  function automatic logic [7:0] kchar_of(input logic [1:0] sel);
    case (sel)
      EOF_SEL_K28_1: return KCHAR_28_1;
      EOF_SEL_K28_5: return KCHAR_28_5;
      default:       return KCHAR_28_7;
    endcase
  endfunction : kchar_of

  // Both pins cross into hclk through two flops
  slps_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({pll_lock_pin, sync_n_pin}),
    .sync_out (pin_sync)
  );

  assign sync_n_s   = pin_sync[0];
  assign pll_lock_s = pin_sync[1];

  // Next state: bus writes first, then hardware sets, then read capture
  always_comb
  begin
    logic       take;
    logic       do_wr;
    logic [7:0] wb;
    logic [7:0] rb;
    logic       dig_b;
    dig_b = 1'b0;
    st_d  = st_q;
    take  = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
    do_wr = st_q.wr_pend;
    wb    = hwdata[7:0];
    rb    = 8'h00;
    // Data phase of a write lands here, whether or not the link is live
    if (do_wr)
    begin
      case (st_q.wr_idx)
        IDX_ILAS_DEVICE_ID:   st_d.ilas_device_id = {wb[7:1], 1'b0};
        IDX_END_OF_FRAME_SEL: st_d.end_of_frame_char_sel = wb[1:0];
        IDX_CHANNEL_PWR_OFF:  st_d.pd = wb[1:0];
        IDX_IRQ_MASK:         st_d.irq_mask = wb[IRQ_W-1:0];
        IDX_IRQ_STATUS:       st_d.irq_stat = st_q.irq_stat & ~wb[IRQ_W-1:0];
        IDX_LINK_STATUS:
        begin
          if (wb[STAT_REALIGN_BIT])
            st_d.realigned = 1'b0;
          if (wb[STAT_PHASE_SET_BIT])
            st_d.phase_set = 1'b0;
        end
        default: st_d.ilas_device_id = st_q.ilas_device_id;
      endcase
    end
    // Live status levels
    st_d.link_up  = link_up_in;
    st_d.sync_ok  = sync_n_s;
    st_d.pll_lock = pll_lock_s;
    // Sticky flags; a set in the clearing cycle wins
    if (sysref_realign)
      st_d.realigned = 1'b1;
    st_d.en_prev = serial_link_enable;
    if (serial_link_enable && !st_q.en_prev)
      st_d.armed = 1'b1;
    else if (!serial_link_enable)
      st_d.armed = 1'b0;
    if (sysref_event && st_q.armed)
    begin
      st_d.phase_set = 1'b1;
      st_d.armed     = 1'b0;
    end
    // Interrupt events; set wins over the write-one clear above
    if (sysref_realign)
      st_d.irq_stat[IRQ_REALIGN_BIT] = 1'b1;
    if (sysref_event && st_q.armed)
      st_d.irq_stat[IRQ_PHASE_SET_BIT] = 1'b1;
    if (link_up_in && !st_q.link_up)
      st_d.irq_stat[IRQ_LINK_UP_BIT] = 1'b1;
    if (!pll_lock_s && st_q.pll_lock)
      st_d.irq_stat[IRQ_PLL_LOSS_BIT] = 1'b1;
    // Address phase: latch write target, capture read from updated values; the three status levels are read from current flops
    st_d.wr_pend = take && hwrite;
    st_d.wr_idx  = idx_of(haddr);
    if (take && !hwrite)
    begin
      case (idx_of(haddr))
        IDX_ILAS_DEVICE_ID:   rb = st_d.ilas_device_id;
        IDX_END_OF_FRAME_SEL: rb = {6'h00, st_d.end_of_frame_char_sel};
        IDX_CHANNEL_PWR_OFF:  rb = {6'h00, st_d.pd};
        IDX_IRQ_STATUS:       rb = {4'h0, st_d.irq_stat};
        IDX_IRQ_MASK:         rb = {4'h0, st_d.irq_mask};
        IDX_LINK_STATUS:
        begin
          rb[STAT_LINK_UP_BIT]   = st_q.link_up;
          rb[STAT_SYNC_BIT]      = st_q.sync_ok;
          rb[STAT_REALIGN_BIT]   = st_d.realigned;
          rb[STAT_PHASE_SET_BIT] = st_d.phase_set;
          rb[STAT_PLL_LOCK_BIT]  = st_q.pll_lock;
        end
        default: rb = 8'h00;
      endcase
      st_d.rdata = {24'h000000, rb};
    end
    // ILAS identifier octets, zero outside the second multiframe
    st_d.did_a = ilas_mf2_a ? st_q.ilas_device_id : 8'h00;
    st_d.did_b = ilas_mf2_b ? 8'(st_q.ilas_device_id + DID_LINK_B_STEP) : 8'h00;
    // Comma only where encoding is 8b/10b; other modes ignore the select
    st_d.eof_ins = eof_opportunity && mode_8b10b;
    st_d.eof_k   = kchar_of(st_q.end_of_frame_char_sel);
    // Digital channels follow the converter they are bound to (1 = bound to B)
    for (int i = 0; i < 2; i++)
    begin
      dig_b = digital_channel_binding[i];
      st_d.dig_pd[i] = dig_b ? st_q.pd[PD_CHAN_B_BIT] : st_q.pd[PD_CHAN_A_BIT];
    end
    st_d.subsys_pd = &st_q.pd;
    // Link A keeps running; flag that its B samples carry no meaning
    st_d.b_undef = mode_ab_on_link_a && !digital_channel_enable[1] && !(&st_q.pd);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q          <= '0;
      st_q.ilas_device_id      <= RST_ILAS_DEVICE_ID;
      st_q.end_of_frame_char_sel    <= RST_EOF_CHAR_SEL;
      st_q.pd       <= RST_CHAN_PWR_OFF;
      st_q.irq_mask <= RST_IRQ_MASK;
    end
    else
      st_q <= st_d;
  end

  // Zero-wait slave, always OKAY
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = st_q.rdata;
  assign did_octet_a      = st_q.did_a;
  assign did_octet_b      = st_q.did_b;
  assign eof_insert       = st_q.eof_ins;
  assign eof_kchar        = st_q.eof_k;
  assign chan_a_power_off = st_q.pd[PD_CHAN_A_BIT];
  assign chan_b_power_off = st_q.pd[PD_CHAN_B_BIT];
  assign digital_chan_pd  = st_q.dig_pd;
  assign link_subsys_pd   = st_q.subsys_pd;
  assign b_samples_undef  = st_q.b_undef;
  assign irq              = |(st_q.irq_stat & st_q.irq_mask);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  did_link_b_a: assert property (ilas_mf2_b
                                 |=> did_octet_b == 8'($past(st_q.ilas_device_id) + DID_LINK_B_STEP))
    else $error("link B identifier is not identifier plus one");
  did_link_a_a: assert property (!ilas_mf2_a |=> did_octet_a == 8'h00)
    else $error("link A identifier sent outside second multiframe");
  // Stored value is the written byte with bit 0 forced low
  did_even_a: assert property (st_q.wr_pend && st_q.wr_idx == IDX_ILAS_DEVICE_ID
                               |=> st_q.ilas_device_id == {$past(hwdata[7:1]), 1'b0})
    else $error("identifier not stored as even value");
  eof_code_a: assert property (eof_opportunity && mode_8b10b && st_q.end_of_frame_char_sel == 2'h1
                               |=> eof_insert && eof_kchar == 8'h3c)
    else $error("comma select 1 did not give K28.1");
  eof_mode_a: assert property (!mode_8b10b |=> !eof_insert)
    else $error("comma inserted outside 8b/10b mode");
  link_up_bit_a: assert property (link_up_in ##1 link_up_in |=> st_q.link_up)
    else $error("link up status not shown");
  sync_stat_a: assert property (!sync_n_pin [*4] |-> !st_q.sync_ok)
    else $error("sync status not zero while SYNC asserted");
  // Flag may drop in the second cycle only through a write-one clear landing then
  realign_set_a: assert property (sysref_realign
                                  |=> st_q.realigned && st_q.irq_stat[IRQ_REALIGN_BIT]
                                  ##1 (st_q.realigned || $past(st_q.wr_pend
                                       && st_q.wr_idx == IDX_LINK_STATUS
                                       && hwdata[STAT_REALIGN_BIT])))
    else $error("realign flag not set by SYSREF");
  phase_first_a: assert property ($rose(st_q.phase_set)
                                  |-> $past(sysref_event) && $past(st_q.armed))
    else $error("phase flag set without first SYSREF after enable");
  pll_lock_a: assert property (pll_lock_pin [*4] |-> st_q.pll_lock)
    else $error("PLL lock status not shown");
  dig_pd_b_a: assert property (st_q.pd[1] && digital_channel_binding[0]
                               |=> digital_chan_pd[0])
    else $error("digital channel bound to B not powered down");
  dig_pd_a_a: assert property (st_q.pd[0] && !digital_channel_binding[1]
                               |=> digital_chan_pd[1])
    else $error("digital channel bound to A not powered down");
  subsys_pd_a: assert property (st_q.pd == 2'h3 |=> link_subsys_pd)
    else $error("subsystem not powered down with both channels off");
  b_undef_a: assert property (b_samples_undef
                              |-> !link_subsys_pd ##0 $past(mode_ab_on_link_a))
    else $error("undefined B samples flagged without shared link A");

  realign_c: cover property (sysref_realign ##1 st_q.realigned);
  phase_c: cover property (serial_link_enable ##[1:20] $rose(st_q.phase_set));
  irq_c: cover property ($rose(irq));
  subsys_c: cover property ($rose(link_subsys_pd));

endmodule : slps_regs

/* File: tb/slps_tb.sv */
`timescale 1ns/1ps
module tb;
  import slps_pkg::*;
  // Bus side
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [15:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, v;
  // Link side
  logic        sync_n_pin, pll_lock_pin, serial_link_enable, link_up_in, mode_8b10b;
  logic        mode_ab_on_link_a, sysref_realign, sysref_event, ilas_mf2_a, ilas_mf2_b;
  logic        eof_opportunity, eof_insert, chan_a_power_off, chan_b_power_off;
  logic        link_subsys_pd, b_samples_undef, irq;
  logic [1:0]  digital_channel_binding, digital_channel_enable, digital_chan_pd;
  logic [7:0]  did_octet_a, did_octet_b, eof_kchar, idv;
  int          n_errors = 0;
  int          total_checks = 0;
  int          i;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 10 MHz clock
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  slps_regs uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_n_pin(sync_n_pin),
    .pll_lock_pin(pll_lock_pin), .serial_link_enable(serial_link_enable),
    .link_up_in(link_up_in), .mode_8b10b(mode_8b10b), .mode_ab_on_link_a(mode_ab_on_link_a),
    .digital_channel_binding(digital_channel_binding),
    .digital_channel_enable(digital_channel_enable), .sysref_realign(sysref_realign),
    .sysref_event(sysref_event), .ilas_mf2_a(ilas_mf2_a), .ilas_mf2_b(ilas_mf2_b),
    .eof_opportunity(eof_opportunity), .did_octet_a(did_octet_a), .did_octet_b(did_octet_b),
    .eof_insert(eof_insert), .eof_kchar(eof_kchar), .chan_a_power_off(chan_a_power_off),
    .chan_b_power_off(chan_b_power_off), .digital_chan_pd(digital_chan_pd),
    .link_subsys_pd(link_subsys_pd), .b_samples_undef(b_samples_undef), .irq(irq)
  );

  task automatic test_done();
    $display("Checks: %0d, errors: %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One transfer: address phase held until ready, then data phase held until ready
  task automatic bus_xfer(input logic [11:0] idx, input logic wr, input logic [7:0] d,
                          output logic [31:0] q);
    @(posedge hclk);
    haddr  <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus_xfer

  task automatic bus_wr(input logic [11:0] idx, input logic [7:0] d);
    bus_xfer(idx, 1'b1, d, rd);
  endtask : bus_wr

  task automatic rd_chk(input string n, input logic [11:0] idx, input logic [31:0] e);
    bus_xfer(idx, 1'b0, 8'h00, rd);
    chk(n, rd, e);
  endtask : rd_chk

  // Outputs are registered, so look just after the last edge
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  function automatic logic [31:0] kchar_exp(input logic [1:0] s);
    case (s)
      2'h1:    return 32'h3c;
      2'h2:    return 32'hbc;
      default: return 32'hfc;
    endcase
  endfunction : kchar_exp

  function automatic logic [31:0] stat_of(input logic lu, sy, ra, ph, pl);
    return {25'h0, lu, sy, ra, ph, pl, 2'h0};
  endfunction : stat_of

  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    test_done();
  end

  initial
  begin
    {hresetn, haddr, htrans, hwrite, hwdata, sync_n_pin, pll_lock_pin} = '0;
    {serial_link_enable, link_up_in, mode_8b10b, mode_ab_on_link_a, sysref_realign} = '0;
    {sysref_event, ilas_mf2_a, ilas_mf2_b, eof_opportunity, digital_channel_binding} = '0;
    hsel = 1'b1;
    hsize = 3'h2;
    digital_channel_enable = 2'h3;
    v = $urandom(32'h40db0046);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("device_id", IDX_ILAS_DEVICE_ID, 32'h0);
    rd_chk("char_sel", IDX_END_OF_FRAME_SEL, 32'h0);
    rd_chk("status", IDX_LINK_STATUS, 32'h0);
    rd_chk("power_off", IDX_CHANNEL_PWR_OFF, 32'h0);
    // Identifier: odd values and the top value among random ones
    for (i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 32'hff : (i == 1) ? 32'h01 : $urandom;
      idv = {v[7:1], 1'b0};
      bus_wr(IDX_ILAS_DEVICE_ID, v[7:0]);
      rd_chk("device_id", IDX_ILAS_DEVICE_ID, {24'h0, idv});
      ilas_mf2_a <= 1'b1;
      ilas_mf2_b <= 1'b1;
      settle(1);
      chk("octet_a", {24'h0, did_octet_a}, {24'h0, idv});
      chk("octet_b", {24'h0, did_octet_b}, {24'h0, idv + 8'h01});
      @(posedge hclk);
      ilas_mf2_a <= 1'b0;
      ilas_mf2_b <= 1'b0;
    end
    // Every comma code, with and without 8b/10b mode
    for (i = 0; i < 4; i++)
    begin
      bus_wr(IDX_END_OF_FRAME_SEL, 8'(i));
      rd_chk("char_sel", IDX_END_OF_FRAME_SEL, 32'(i));
      mode_8b10b <= 1'b1;
      eof_opportunity <= 1'b1;
      settle(2);
      chk("kchar", {24'h0, eof_kchar}, kchar_exp(2'(i)));
      chk("insert_on", 32'(eof_insert), 32'h1);
      @(posedge hclk);
      mode_8b10b <= 1'b0;
      settle(2);
      chk("insert_off", 32'(eof_insert), 32'h0);
    end
    bus_wr(IDX_END_OF_FRAME_SEL, 8'h00);
    // Level status from link and pins
    @(posedge hclk);
    {link_up_in, sync_n_pin, pll_lock_pin} <= 3'h7;
    settle(5);
    rd_chk("status", IDX_LINK_STATUS, stat_of(1, 1, 0, 0, 1));
    sync_n_pin <= 1'b0;
    settle(5);
    rd_chk("status", IDX_LINK_STATUS, stat_of(1, 0, 0, 0, 1));
    @(posedge hclk);
    sysref_realign <= 1'b1;
    @(posedge hclk);
    sysref_realign <= 1'b0;
    rd_chk("status", IDX_LINK_STATUS, stat_of(1, 0, 1, 0, 1));
    // Phase flag needs an enable edge, then only the first event counts
    @(posedge hclk);
    serial_link_enable <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      @(posedge hclk);
      sysref_event <= 1'b1;
      @(posedge hclk);
      sysref_event <= 1'b0;
      rd_chk("status", IDX_LINK_STATUS, stat_of(1, 0, i == 0, i == 0, 1));
      bus_wr(IDX_LINK_STATUS, 8'h18);
    end
    rd_chk("status", IDX_LINK_STATUS, stat_of(1, 0, 0, 0, 1));
    {link_up_in, pll_lock_pin} <= 2'h0;
    settle(5);
    rd_chk("status", IDX_LINK_STATUS, 32'h0);
    // Interrupt raised while masked, then enabled, then cleared
    bus_wr(IDX_IRQ_STATUS, 8'h0f);
    rd_chk("irq_mask", IDX_IRQ_MASK, 32'h0);
    @(posedge hclk);
    sysref_realign <= 1'b1;
    @(posedge hclk);
    sysref_realign <= 1'b0;
    settle(2);
    chk("irq_masked", 32'(irq), 32'h0);
    rd_chk("irq_status", IDX_IRQ_STATUS, 32'h1);
    bus_wr(IDX_IRQ_MASK, 8'h01);
    settle(2);
    chk("irq_on", 32'(irq), 32'h1);
    bus_wr(IDX_IRQ_STATUS, 8'h01);
    settle(2);
    chk("irq_clr", 32'(irq), 32'h0);
    bus_wr(12'h20a, 8'h5a);
    rd_chk("unmapped", 12'h20a, 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
    // Power-off codes under random binding and mode
    // No foreground calibration runs here, so no converter-off write is due
    @(posedge hclk);
    serial_link_enable <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      v = $urandom;
      if (i == 1)
        v[4:2] = 3'h1;
      @(posedge hclk);
      digital_channel_binding <= v[1:0];
      mode_ab_on_link_a <= v[2];
      digital_channel_enable <= v[4:3];
      bus_wr(IDX_CHANNEL_PWR_OFF, 8'(i % 4));
      settle(2);
      chk("chan_a", 32'(chan_a_power_off), 32'(i % 2));
      chk("chan_b", 32'(chan_b_power_off), 32'((i / 2) % 2));
      chk("dig_pd", 32'(digital_chan_pd), {30'h0, v[1] ? i[1] : i[0],
          v[0] ? i[1] : i[0]});
      chk("subsys_pd", 32'(link_subsys_pd), 32'(i % 4 == 3));
      chk("b_undef", 32'(b_samples_undef), 32'(v[2] & ~v[4] & (i % 4 != 3)));
      rd_chk("power_off", IDX_CHANNEL_PWR_OFF, 32'(i % 4));
    end
    test_done();
  end
endmodule : tb
